// [hdl/irq_consts.svh]
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// Register word indices; the byte address is four times the index
`define IRQ_OFS_FLAGS     6'h00
`define IRQ_OFS_ENABLES   6'h03
`define IRQ_OFS_PRIO      6'h08
`define IRQ_OFS_CTRL1     6'h14
`define IRQ_OFS_CTRL2     6'h15
`define IRQ_OFS_STATUS    6'h16
`define IRQ_OFS_CORECTL   6'h17

// Field positions
`define IRQ_NESTING_DISABLE_BIT    15
`define IRQ_ALTIVT_BIT    15
`define IRQ_TIMED_LOW_PRIORITY_MASK_BIT      14
`define IRQ_IPL3_BIT      3

// Reset values and fixed figures
`define IRQ_RST_WORD      16'h0000
`define IRQ_RST_LEVEL     4'h0
`define IRQ_VEC_OFFSET    8'h08
`define IRQ_IMPL_MASK     48'h067F_FFFF_FFFF
`define IRQ_TIMED_LOW_PRIORITY_MASK_PASS     3'h7
`define IRQ_VSPACE_LO     24'h000004
`define IRQ_VSPACE_HI     24'h0000FE
`define IRQ_IVT_BASE      24'h000004
`define IRQ_ALTERNATE_VECTOR_TABLE_BASE     24'h000084

// Trap levels and vectors
`define IRQ_TRAP_LVL_OSC  4'hE
`define IRQ_TRAP_LVL_STK  4'hD
`define IRQ_TRAP_LVL_ADR  4'hC
`define IRQ_TRAP_LVL_MTH  4'hB
`define IRQ_TRAP_VEC_OSC  8'h01
`define IRQ_TRAP_VEC_ADR  8'h02
`define IRQ_TRAP_VEC_STK  8'h03
`define IRQ_TRAP_VEC_MTH  8'h04

`endif

// [hdl/irq_controller.sv]
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "irq_consts.svh"

// Summary of operation
// - Arbitrate 41 sources plus 4 traps.
// - Flags set regardless of enable.
// - Only software clears flags.
// - Per-source enable in three registers.
// - Priorities 1..7, seven highest.
// - Priority zero never serviced.
// - Priority in nibble low bits, top zero.
// - Equal priorities resolved by natural order.
// - Natural rank equals source number.
// - Vector is source plus eight.
// - Nesting disable blocks nested non-trap interrupts.
// - Nesting disable makes level read-only.
// - Timed mask holds off levels six down.
// - CPU level four bits, split registers.
// - Vector table in program words 4..FE.
// - Fetched vector loads program counter.
// - Vector-space fetch or jump traps.
// - Second control: table, external config.
// - Flags sampled each instruction start.
// - Interrupt only above CPU level.
// - Taken interrupt raises CPU level.
module irq_controller #(
    parameter int NSRC = 48,
    parameter int IW   = 6
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Peripheral and trap events
    input  wire logic [NSRC-1:0]  srcEvent,
    input  wire logic [3:0]       trapEvent,
    // Core handshake
    input  wire logic             instrStrobe,
    output logic                  irqReq,
    output logic      [7:0]       irqVector,
    output irq_pkg::level_t       irqLevel,
    input  wire logic             irqAck,
    input  wire logic             irqReturn,
    input  wire irq_pkg::level_t  retLevel,
    output irq_pkg::level_t       cpuLevel,
    // Timed low priority mask
    input  wire logic             disiStart,
    input  wire logic [13:0]      disiCount,
    // Program counter path
    input  wire logic [23:0]      fetchAddr,
    input  wire logic             fetchValid,
    input  wire logic             fetchIsVector,
    input  wire logic             jumpValid,
    input  wire logic [23:0]      jumpTarget,
    input  wire logic [23:0]      progData,
    input  wire logic             vectorLoad,
    output logic      [23:0]      pcLoad,
    output logic      [23:0]      vectorAddr,
    output logic                  addrErr,
    // External request configuration
    output logic      [4:0]       extEdgePol
);
    import irq_pkg::*;

    // Bus and register state
    bus_state_t        st_ff;
    logic [5:0]        idx_ff;
    logic [31:0]       rdat_ff;
    logic [NSRC-1:0]   flags_ff;
    logic [NSRC-1:0]   enab_ff;
    logic [NSRC-1:0]   samp_ff;
    prio_t             prio_ff [NSRC];
    logic              nesting_disable_ff;
    logic [3:0]        trapFlags_ff;
    logic              altivt_ff;
    logic [4:0]        edge_ff;
    level_t            ipl_ff;
    logic [3:0]        depth_ff;
    logic              winV_ff;
    logic              winTrap_ff;
    level_t            winLvl_ff;
    logic [7:0]        winVec_ff;
    logic [23:0]       pc_ff;
    logic [23:0]       vaddr_ff;
    logic              addrErr_ff;
    logic              disiActive;

    // Address phase acceptance; reads take one wait state so a write just
    // before is already visible
    wire         acc   = hsel & htrans[1] & hready;
    wire         wrEn  = (st_ff == BUS_WRITE);
    wire [15:0]  wd    = hwdata[15:0];
    wire [5:0]   widx  = idx_ff;
    bus_state_t  nxt_st;
    assign nxt_st = acc ? (hwrite ? BUS_WRITE : BUS_RWAIT)
                  : (st_ff == BUS_RWAIT) ? BUS_RDONE : BUS_IDLE;
    assign hreadyout = (st_ff != BUS_RWAIT);
    assign hresp     = 1'b0;
    assign hrdata    = rdat_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff  <= BUS_IDLE;
            idx_ff <= 6'h3F;
        end else begin
            st_ff  <= nxt_st;
            idx_ff <= acc ? haddr[7:2] : idx_ff;
        end
    end

    // Register selects
    wire [2:0] selFlag;
    wire [2:0] selEnab;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sel
            assign selFlag[g] = wrEn && widx == `IRQ_OFS_FLAGS + 6'(g);
            assign selEnab[g] = wrEn && widx == `IRQ_OFS_ENABLES + 6'(g);
        end
    endgenerate
    wire selCtrl1 = wrEn && widx == `IRQ_OFS_CTRL1;
    wire selCtrl2 = wrEn && widx == `IRQ_OFS_CTRL2;
    wire selStat  = wrEn && widx == `IRQ_OFS_STATUS;
    wire selCore  = wrEn && widx == `IRQ_OFS_CORECTL;

    // Flags: software writes the word, events OR in so a set beats a clear
    wire [NSRC-1:0] implMask = `IRQ_IMPL_MASK;
    wire [NSRC-1:0] evImpl   = srcEvent & implMask;
    wire [NSRC-1:0] wrMask   = {{16{selFlag[2]}}, {16{selFlag[1]}}, {16{selFlag[0]}}};
    wire [NSRC-1:0] enMask   = {{16{selEnab[2]}}, {16{selEnab[1]}}, {16{selEnab[0]}}};
    wire [NSRC-1:0] wd3      = {3{wd}};
    wire [NSRC-1:0] nxt_flags = (((flags_ff & ~wrMask) | (wd3 & wrMask)) | evImpl)
                              & implMask;
    wire [NSRC-1:0] nxt_enab  = ((enab_ff & ~enMask) | (wd3 & enMask)) & implMask;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= '0;
            enab_ff  <= '0;
            samp_ff  <= '0;
        end else begin
            flags_ff <= nxt_flags;
            enab_ff  <= nxt_enab;
            samp_ff  <= instrStrobe ? (flags_ff & enab_ff) : samp_ff;
        end
    end

    // Priority fields, four sources to a register
    generate
        for (g = 0; g < NSRC; g++) begin : g_prio
            wire sel = wrEn && widx == `IRQ_OFS_PRIO + 6'(g / 4);
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prio_ff[g] <= 3'h0;
                end else if (sel && implMask[g]) begin
                    prio_ff[g] <= wd[(g % 4) * 4 +: 3];
                end
            end
        end
    endgenerate

    // Trap flags: events and the vector-space guard set, software clears
    wire [3:0] trapSet   = trapEvent | {2'b00, addrErr_ff, 1'b0};
    wire [3:0] nxt_traps = (selCtrl1 ? wd[4:1] : trapFlags_ff) | trapSet;

    // Current CPU level: taken interrupt, return, then software
    wire    swIpl = !nesting_disable_ff;
    wire    take  = irqAck & irqReq;
    level_t nxt_ipl;
    assign nxt_ipl = take ? winLvl_ff
                   : irqReturn ? retLevel
                   : (swIpl && selStat) ? {ipl_ff[3], wd[2:0]}
                   : (swIpl && selCore) ? {wd[`IRQ_IPL3_BIT], ipl_ff[2:0]}
                   : ipl_ff;
    wire [3:0] nxt_depth = take ? depth_ff + 4'h1
                         : (irqReturn && depth_ff != 4'h0) ? depth_ff - 4'h1 : depth_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nesting_disable_ff    <= 1'b0;
            trapFlags_ff <= 4'h0;
            altivt_ff    <= 1'b0;
            edge_ff      <= 5'h00;
            ipl_ff       <= `IRQ_RST_LEVEL;
            depth_ff     <= 4'h0;
        end else begin
            nesting_disable_ff    <= selCtrl1 ? wd[`IRQ_NESTING_DISABLE_BIT] : nesting_disable_ff;
            trapFlags_ff <= nxt_traps;
            altivt_ff    <= selCtrl2 ? wd[`IRQ_ALTIVT_BIT] : altivt_ff;
            edge_ff      <= selCtrl2 ? wd[4:0] : edge_ff;
            ipl_ff       <= nxt_ipl;
            depth_ff     <= nxt_depth;
        end
    end

    // Timed mask of levels six and below
    timed_low_priority_mask_timer #(.CW(14)) u_timed_low_priority_mask (
        .clk         (clk),
        .rst_n       (rst_n),
        .start       (disiStart),
        .count       (disiCount),
        .instrStrobe (instrStrobe),
        .active      (disiActive)
    );

    // Arbitration chain walks from source 0 so lower numbers win ties
    logic [NSRC:0] chV;
    prio_t         chL [NSRC+1];
    logic [IW-1:0] chI [NSRC+1];
    assign chV[0] = 1'b0;
    assign chL[0] = 3'h0;
    assign chI[0] = '0;
    generate
        for (g = 0; g < NSRC; g++) begin : g_arb
            wire cv = samp_ff[g] && prio_ff[g] != 3'h0
                   && (!disiActive || prio_ff[g] == `IRQ_TIMED_LOW_PRIORITY_MASK_PASS);
            prio_pick #(.IW(IW)) u_pick (
                .inValid   (chV[g]),
                .inLvl     (chL[g]),
                .inIdx     (chI[g]),
                .candValid (cv),
                .candLvl   (prio_ff[g]),
                .candIdx   (IW'(g)),
                .outValid  (chV[g+1]),
                .outLvl    (chL[g+1]),
                .outIdx    (chI[g+1])
            );
        end
    endgenerate

    // Traps outrank every maskable source; highest trap level first
    wire [3:0] tf      = trapFlags_ff;
    wire       trapAny = |tf;
    wire [7:0] trapVec = tf[0] ? `IRQ_TRAP_VEC_OSC : tf[2] ? `IRQ_TRAP_VEC_STK
                       : tf[1] ? `IRQ_TRAP_VEC_ADR : `IRQ_TRAP_VEC_MTH;
    level_t    trapLvl;
    assign trapLvl = tf[0] ? `IRQ_TRAP_LVL_OSC : tf[2] ? `IRQ_TRAP_LVL_STK
                   : tf[1] ? `IRQ_TRAP_LVL_ADR : `IRQ_TRAP_LVL_MTH;
    wire [7:0] srcVec  = {2'b00, chI[NSRC]} + `IRQ_VEC_OFFSET;
    wire [23:0] vbase  = altivt_ff ? `IRQ_ALTERNATE_VECTOR_TABLE_BASE : `IRQ_IVT_BASE;

    // Guard on vector space for fetches and jumps
    wire fetchBad = fetchValid && !fetchIsVector
                 && fetchAddr >= `IRQ_VSPACE_LO && fetchAddr <= `IRQ_VSPACE_HI;
    wire jumpBad  = jumpValid
                 && jumpTarget >= `IRQ_VSPACE_LO && jumpTarget <= `IRQ_VSPACE_HI;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            winV_ff    <= 1'b0;
            winTrap_ff <= 1'b0;
            winLvl_ff  <= `IRQ_RST_LEVEL;
            winVec_ff  <= 8'h00;
            vaddr_ff   <= 24'h000000;
            pc_ff      <= 24'h000000;
            addrErr_ff <= 1'b0;
        end else begin
            winV_ff    <= trapAny | chV[NSRC];
            winTrap_ff <= trapAny;
            winLvl_ff  <= trapAny ? trapLvl : {1'b0, chL[NSRC]};
            winVec_ff  <= trapAny ? trapVec : srcVec;
            vaddr_ff   <= vbase + {15'h0000, (trapAny ? trapVec : srcVec), 1'b0};
            pc_ff      <= vectorLoad ? progData : pc_ff;
            addrErr_ff <= fetchBad | jumpBad;
        end
    end

    // Request only above the CPU level; nesting disable blocks non-trap requests while busy
    wire nestBlock = nesting_disable_ff && depth_ff != 4'h0 && !winTrap_ff;
    assign irqReq     = winV_ff && (winLvl_ff > ipl_ff) && !nestBlock;
    assign irqVector  = winVec_ff;
    assign irqLevel   = winLvl_ff;
    assign cpuLevel   = ipl_ff;
    assign pcLoad     = pc_ff;
    assign vectorAddr = vaddr_ff;
    assign addrErr    = addrErr_ff;
    assign extEdgePol = edge_ff;

    // Read mux; unmapped words read as zero
    function automatic logic [15:0] prioWord(input logic [5:0] r);
        logic [15:0] w;
        w = 16'h0000;
        for (int k = 0; k < 4; k++) begin
            if (int'(r) * 4 + k < NSRC) begin
                w[k*4 +: 4] = {1'b0, prio_ff[int'(r) * 4 + k]};
            end
        end
        return w;
    endfunction

    wire [5:0]  pr   = idx_ff - `IRQ_OFS_PRIO;
    wire        inPr = idx_ff >= `IRQ_OFS_PRIO && idx_ff < `IRQ_OFS_PRIO + 6'(NSRC / 4);
    wire [15:0] rdW =
        (idx_ff == `IRQ_OFS_FLAGS)         ? flags_ff[15:0]  :
        (idx_ff == `IRQ_OFS_FLAGS + 6'h1)  ? flags_ff[31:16] :
        (idx_ff == `IRQ_OFS_FLAGS + 6'h2)  ? flags_ff[47:32] :
        (idx_ff == `IRQ_OFS_ENABLES)       ? enab_ff[15:0]   :
        (idx_ff == `IRQ_OFS_ENABLES + 6'h1)? enab_ff[31:16]  :
        (idx_ff == `IRQ_OFS_ENABLES + 6'h2)? enab_ff[47:32]  :
        inPr                               ? prioWord(pr)    :
        (idx_ff == `IRQ_OFS_CTRL1)   ? {nesting_disable_ff, 10'h000, trapFlags_ff, 1'b0} :
        (idx_ff == `IRQ_OFS_CTRL2)   ? {altivt_ff, disiActive, 9'h000, edge_ff} :
        (idx_ff == `IRQ_OFS_STATUS)  ? {13'h0000, ipl_ff[2:0]} :
        (idx_ff == `IRQ_OFS_CORECTL) ? {12'h000, ipl_ff[3], 3'h0} : `IRQ_RST_WORD;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_ff <= 32'h0000_0000;
        end else if (st_ff == BUS_RWAIT) begin
            rdat_ff <= {16'h0000, rdW};
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_flag_sticky: assert property (!(|selFlag) |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
        else $error("request flag cleared without a software write");
    a_event_sets: assert property ((|evImpl) |=> ((flags_ff & $past(evImpl)) == $past(evImpl)))
        else $error("source event did not set its flag");
    a_reserved_zero: assert property ((flags_ff & ~implMask) == '0)
        else $error("reserved source flag is set");
    a_req_above: assert property (irqReq |-> (winLvl_ff > cpuLevel))
        else $error("request not above cpu level");
    a_nest_block: assert property ((nesting_disable_ff && depth_ff != 4'h0 && !winTrap_ff) |-> !irqReq)
        else $error("nested request while nesting disabled");
    a_ipl_readonly: assert property ((nesting_disable_ff && !irqAck && !irqReturn) |=> $stable(ipl_ff))
        else $error("cpu level changed while read-only");
    a_ack_level: assert property ((irqAck && irqReq) |=> (ipl_ff == $past(winLvl_ff) && depth_ff != 4'h0))
        else $error("cpu level not raised on taken interrupt");
    a_prio_zero: assert property ((winV_ff && !winTrap_ff) |-> winLvl_ff != 4'h0)
        else $error("priority zero source selected");
    a_timed_low_priority_mask_mask: assert property ((winV_ff && !winTrap_ff && $past(disiActive)) |-> winLvl_ff == 4'h7)
        else $error("low priority passed during timed mask");
    a_read_wait: assert property ((st_ff == BUS_RWAIT) |-> !hreadyout ##1 hreadyout)
        else $error("read wait state not one cycle");
endmodule

// [hdl/irq_pkg.sv]
package irq_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_RWAIT = 2'b11,
        BUS_RDONE = 2'b10
    } bus_state_t;
    typedef logic [2:0] prio_t;
    typedef logic [3:0] level_t;
endpackage

// [hdl/prio_pick.sv]
`timescale 1ns/1ps
// One stage of the arbitration chain: keeps the incoming winner unless
// the candidate is strictly higher, so ties go to the lower source number.
module prio_pick #(
    parameter int IW = 6
) (
    // Winner so far
    input  wire logic           inValid,
    input  wire irq_pkg::prio_t inLvl,
    input  wire logic [IW-1:0]  inIdx,
    // This stage's candidate
    input  wire logic           candValid,
    input  wire irq_pkg::prio_t candLvl,
    input  wire logic [IW-1:0]  candIdx,
    // Winner after this stage
    output logic                outValid,
    output irq_pkg::prio_t      outLvl,
    output logic [IW-1:0]       outIdx
);
    import irq_pkg::*;

    // Strict compare keeps natural order among equal levels
    wire take = candValid & (!inValid | (candLvl > inLvl));
    assign outValid = inValid | candValid;
    assign outLvl   = take ? candLvl : inLvl;
    assign outIdx   = take ? candIdx : inIdx;
endmodule

// [hdl/timed_low_priority_mask_timer.sv]
`timescale 1ns/1ps
// Counts instructions while low priorities are held off
module timed_low_priority_mask_timer #(
    parameter int CW = 14
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Core side
    input  wire logic          start,
    input  wire logic [CW-1:0] count,
    input  wire logic          instrStrobe,
    // Status
    output logic               active
);
    import irq_pkg::*;

    logic [CW-1:0] cnt_ff;
    wire  [CW-1:0] nxt_cnt = start ? count
                           : (instrStrobe && cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;

    // Restart wins over the running count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign active = (cnt_ff != '0);

    a_timed_low_priority_mask_count: assert property (@(posedge clk) disable iff (!rst_n)
        (active && instrStrobe && !start) |=> (cnt_ff == $past(cnt_ff) - CW'(1)))
        else $error("low priority mask count did not step down");
endmodule

// [sim/core_model.sv]
`timescale 1ns/1ps
// Core stand-in: takes an offered interrupt after a set delay
module core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Controller side
    input  wire logic       irqReq,
    input  wire logic [7:0] irqVector,
    input  wire logic [3:0] ackDelay,
    output logic            irqAck,
    // Observation
    output logic [7:0]      lastVec,
    output logic [7:0]      ackCnt
);
    logic [3:0] waitCnt_ff;

    // Ack is raised only while the request is seen, one cycle wide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqAck     <= 1'b0;
            lastVec    <= 8'h00;
            ackCnt     <= 8'h00;
            waitCnt_ff <= 4'h0;
        end else if (irqAck) begin
            irqAck     <= 1'b0;
            waitCnt_ff <= 4'h0;
        end else if (irqReq && waitCnt_ff >= ackDelay) begin
            irqAck  <= 1'b1;
            lastVec <= irqVector;
            ackCnt  <= ackCnt + 8'h01;
        end else begin
            waitCnt_ff <= irqReq ? waitCnt_ff + 4'h1 : 4'h0; // Slow mode stalls here
        end
    end
endmodule

// [sim/irq_controller_tb.sv]
`timescale 1ns/1ps
module irq_controller_tb;
    import irq_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [47:0] srcEvent = 48'h0;
    logic [3:0]  trapEvent = 4'h0;
    logic [23:0] fetchAddr = 24'h0;
    logic        fetchValid = 1'b0;
    logic        fetchIsVector = 1'b0;
    logic        instrStrobe = 1'b0;
    logic        irqReq;
    logic [7:0]  irqVector;
    level_t      irqLevel;
    logic        irqAck;
    logic        irqReturn = 1'b0;
    level_t      retLevel = 4'h0;
    level_t      cpuLevel;
    logic        disiStart = 1'b0;
    logic [13:0] disiCount = 14'h0;
    logic        jumpValid = 1'b0;
    logic [23:0] jumpTarget = 24'h0;
    logic [23:0] progData = 24'h0;
    logic        vectorLoad = 1'b0;
    logic [23:0] pcLoad;
    logic [23:0] vectorAddr;
    logic        addrErr;
    logic [4:0]  extEdgePol;
    logic [3:0]  ackDelay = 4'h0;
    logic [7:0]  lastVec;
    logic [7:0]  ackCnt;
    int          badCount = 0;
    int          testsRun = 0;

    irq_controller #(.NSRC(48), .IW(6)) i_irq_controller (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .srcEvent(srcEvent), .trapEvent(trapEvent), .instrStrobe(instrStrobe),
        .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel), .irqAck(irqAck),
        .irqReturn(irqReturn), .retLevel(retLevel), .cpuLevel(cpuLevel), .disiStart(disiStart),
        .disiCount(disiCount), .fetchAddr(fetchAddr), .fetchValid(fetchValid), .fetchIsVector(fetchIsVector),
        .jumpValid(jumpValid), .jumpTarget(jumpTarget), .progData(progData), .vectorLoad(vectorLoad),
        .pcLoad(pcLoad), .vectorAddr(vectorAddr), .addrErr(addrErr), .extEdgePol(extEdgePol)
    );

    core_model i_core_model (
        .clk(clk), .rst_n(rst_n), .irqReq(irqReq), .irqVector(irqVector), .ackDelay(ackDelay),
        .irqAck(irqAck), .lastVec(lastVec), .ackCnt(ackCnt)
    );

    // Clock
    always #25 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One AHB single transfer; waits on the slave, never on a fixed count
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic pulseSrc(input logic [47:0] m);
        @(posedge clk);
        srcEvent <= m;
        @(posedge clk);
        srcEvent <= 48'h0;
    endtask

    task automatic ret(input level_t l);
        @(posedge clk);
        irqReturn <= 1'b1;
        retLevel  <= l;
        @(posedge clk);
        irqReturn <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Waits for the n-th ack, then lets the level update land
    task automatic gotIrq(input logic [7:0] n, input logic [7:0] v);
        for (int i = 0; i < 100 && ackCnt !== n; i++) begin
            @(posedge clk);
        end
        @(negedge clk);
        chk(32'(ackCnt), 32'(n));
        chk(32'(lastVec), 32'(v));
    endtask

    task automatic reportAndStop();
        $display("Checks %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("[ERR] %0t watchdog expired", $time);
        reportAndStop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n       <= 1'b1;
        instrStrobe <= 1'b1; // Every cycle starts an instruction
        // Reset state and register fields
        rdchk(32'h00, 32'h0);
        rdchk(32'h0C, 32'h0);
        rdchk(32'h58, 32'h0);
        rdchk(32'h7C, 32'h0);
        chk(32'(cpuLevel), 32'h0);
        chk(32'(hresp), 32'h0);
        wr(32'h20, 32'hFFFF);
        rdchk(32'h20, 32'h7777);
        pulseSrc(48'hC0_0000_0008); // Source 38 is real, 39 is reserved
        idle(20);
        rdchk(32'h00, 32'h0008);
        rdchk(32'h08, 32'h0040);
        chk(32'(ackCnt), 32'h0);
        $display("test reset and fields done");
        // Priorities, ties and masking by the current level
        wr(32'h00, 32'h0);
        wr(32'h20, 32'h0440);
        wr(32'h24, 32'h0060);
        wr(32'h0C, 32'h002E);
        pulseSrc(48'h2E);
        gotIrq(8'h01, 8'h0D);
        chk(32'(cpuLevel), 32'h6);
        chk(32'(vectorAddr), 32'h1E);
        idle(10);
        chk(32'(irqReq), 32'h0);
        wr(32'h00, 32'h000E);
        ret(4'h0);
        gotIrq(8'h02, 8'h09);
        chk(32'(cpuLevel), 32'h4);
        wr(32'h00, 32'h000C);
        ret(4'h0);
        gotIrq(8'h03, 8'h0A);
        wr(32'h00, 32'h0008);
        ret(4'h0);
        idle(10);
        chk(32'(ackCnt), 32'h3);
        $display("test priority done");
        // Nesting disable, with a slow core
        ackDelay <= 4'h3;
        wr(32'h50, 32'h8000);
        wr(32'h58, 32'h0005);
        rdchk(32'h58, 32'h0);
        wr(32'h20, 32'h0443);
        wr(32'h24, 32'h0066);
        wr(32'h0C, 32'h0011);
        pulseSrc(48'h01);
        gotIrq(8'h04, 8'h08);
        pulseSrc(48'h10);
        idle(10);
        chk(32'(ackCnt), 32'h4);
        ret(4'h0);
        gotIrq(8'h05, 8'h0C);
        wr(32'h00, 32'h0);
        ret(4'h0);
        wr(32'h50, 32'h0);
        $display("test nesting done");
        // Timed low priority mask and external config; the write lands at the edge
        wr(32'h54, 32'h0015);
        @(negedge clk);
        chk(32'(extEdgePol), 32'h15);
        @(posedge clk);
        disiStart <= 1'b1;
        disiCount <= 14'h0028;
        @(posedge clk);
        disiStart <= 1'b0;
        rdchk(32'h54, 32'h4015);
        pulseSrc(48'h10);
        idle(5);
        chk(32'(ackCnt), 32'h5);
        gotIrq(8'h06, 8'h0C);
        wr(32'h00, 32'h0);
        ret(4'h0);
        $display("test timed mask done");
        // Vector load path and vector space guard
        @(posedge clk);
        progData   <= 24'h123456;
        vectorLoad <= 1'b1;
        jumpTarget <= 24'h000010;
        jumpValid  <= 1'b1;
        @(posedge clk);
        vectorLoad <= 1'b0;
        jumpValid  <= 1'b0;
        @(negedge clk);
        chk(32'(pcLoad), 32'h123456);
        chk(32'(addrErr), 32'h1);
        rdchk(32'h50, 32'h0004);
        gotIrq(8'h07, 8'h02);
        // Stack trap outranks the pending address trap and the cpu level
        @(posedge clk);
        trapEvent <= 4'h4;
        @(posedge clk);
        trapEvent <= 4'h0;
        gotIrq(8'h08, 8'h03);
        rdchk(32'h50, 32'h000C);
        // Vector fetch is legal, a plain fetch in vector space is not
        @(posedge clk);
        fetchAddr     <= 24'h000020;
        fetchValid    <= 1'b1;
        fetchIsVector <= 1'b1;
        @(posedge clk);
        fetchIsVector <= 1'b0;
        @(negedge clk);
        chk(32'(addrErr), 32'h0);
        @(posedge clk);
        fetchValid <= 1'b0;
        @(negedge clk);
        chk(32'(addrErr), 32'h1);
        $display("test vector path done");
        reportAndStop();
    end
endmodule
